/* File: drive_operator_panel_logic.sv */
// Purpose: key decoding, lamps and display selection of the operator panel
// Assumes: key and core inputs synchronous to core_clk, keys active high
// Notes: setting values live in a local flip-flop store
`timescale 1ns/1ps
module drive_operator_panel_logic
   import panel_pkg::*;
#(
   parameter int LONG_PRESS_CYCLES_P = LONG_PRESS_CYCLES,
   parameter int DEBOUNCE_CYCLES_P = DEBOUNCE_CYCLES,
   parameter int BLINK_CYCLES_P = BLINK_CYCLES,
   parameter int CODES = 16,
   parameter logic [6:0] MONITOR_CODES = 7'h06,
   parameter logic [15:0] VALUE_MAX = 16'h0FFF
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // keys
   input wire logic key_run,
   input wire logic key_stop_reset,
   input wire logic key_mode,
   input wire logic key_enter,
   input wire logic key_up,
   input wire logic key_down,
   // drive core status and configuration
   input wire logic drive_error,
   input wire logic drive_running,
   input wire logic run_source_panel,
   // monitor quantities
   input wire logic [15:0] mon_out_freq,
   input wire logic [15:0] mon_out_current,
   input wire logic [15:0] mon_freq_ref,
   input wire logic [15:0] mon_out_voltage,
   input wire logic [15:0] mon_out_power,
   input wire logic [15:0] mon_load_ratio,
   // drive core requests
   output logic run_req,
   output logic run_reverse,
   output logic stop_req,
   output logic error_reset_req,
   output logic param_commit,
   output logic [15:0] frequency_setting,
   // lamps
   output logic power_lamp,
   output logic alarm_lamp,
   output logic running_lamp,
   output logic programming_indicator,
   output logic run_source_lamp,
   output logic [4:0] unit_lamp,
   // numeric display
   output logic [2:0] display_group,
   output logic [6:0] display_code,
   output logic display_is_value,
   output logic [15:0] display_value
);

   localparam int DEPTH = 5 * CODES;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [6:0] param_index(input group_t g, input logic [6:0] c);
      int i;
      i = (int'(g) - 1) * CODES + int'(c);
      return 7'(i);
   endfunction : param_index

   function automatic group_t next_group(input group_t g);
      case (g)
         grp_monitor: return grp_basic;
         grp_basic: return grp_ext_a;
         grp_ext_a: return grp_ext_b;
         grp_ext_b: return grp_ext_c;
         grp_ext_c: return grp_ext_h;
         default: return grp_monitor;
      endcase
   endfunction : next_group

   function automatic logic [4:0] unit_of(input group_t g, input logic [6:0] c);
      logic [4:0] u;
      u = 5'h00;
      if (g == grp_monitor) begin
         case (c)
            OUTPUT_FREQUENCY_MONITOR_CODE,
            FREQ_REFERENCE_MONITOR_CODE: u[UNIT_HZ] = 1'b1;
            OUTPUT_CURRENT_MONITOR_CODE: u[UNIT_A] = 1'b1;
            OUTPUT_VOLTAGE_MONITOR_CODE: u[UNIT_V] = 1'b1;
            OUTPUT_POWER_MONITOR_CODE: u[UNIT_KW] = 1'b1;
            default: u[UNIT_PCT] = 1'b1;
         endcase
      end else if (g == grp_basic && c == FREQUENCY_SETTING_PARAM) begin
         u[UNIT_HZ] = 1'b1;
      end else begin
         u[UNIT_PCT] = 1'b1;
      end
      return u;
   endfunction : unit_of

   // ----------------------------------------
   // key debounce
   // ----------------------------------------
   logic [5:0] key_raw;
   logic [5:0] key_sample;
   logic [5:0] key_db;
   logic [5:0] key_db_q;
   logic [31:0] deb_cnt;
   wire deb_tick = (deb_cnt == 32'(DEBOUNCE_CYCLES_P - 1));
   wire [5:0] key_stable = ~(key_sample ^ key_raw);
   wire [5:0] key_press = key_db & ~key_db_q;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         key_raw <= 6'h00;
         key_sample <= 6'h00;
         key_db <= 6'h00;
         key_db_q <= 6'h00;
         deb_cnt <= 32'h0000_0000;
      end else begin
         key_raw <= {key_down, key_up, key_enter, key_mode, key_stop_reset, key_run};
         deb_cnt <= deb_tick ? 32'h0000_0000 : deb_cnt + 32'h0000_0001;
         if (deb_tick) begin
            key_sample <= key_raw;
            key_db <= (key_db & ~key_stable) | (key_raw & key_stable);
         end
         key_db_q <= key_db;
      end
   end

   // ----------------------------------------
   // mode key long press
   // ----------------------------------------
   logic [31:0] hold_cnt;
   wire long_fire = key_db[KEY_MODE] && (hold_cnt == 32'(LONG_PRESS_CYCLES_P - 1));

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_cnt <= 32'h0000_0000;
      end else if (!key_db[KEY_MODE]) begin
         hold_cnt <= 32'h0000_0000;
      end else if (hold_cnt != 32'(LONG_PRESS_CYCLES_P)) begin
         hold_cnt <= hold_cnt + 32'h0000_0001;
      end
   end

   // ----------------------------------------
   // blink timebase
   // ----------------------------------------
   logic [31:0] blink_cnt;
   logic blink_phase;
   wire blink_tick = (blink_cnt == 32'(BLINK_CYCLES_P - 1));

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         blink_cnt <= 32'h0000_0000;
         blink_phase <= 1'b0;
      end else begin
         blink_cnt <= blink_tick ? 32'h0000_0000 : blink_cnt + 32'h0000_0001;
         if (blink_tick) begin
            blink_phase <= ~blink_phase;
         end
      end
   end

   // ----------------------------------------
   // navigation and setting store
   // ----------------------------------------
   group_t group;
   view_t view;
   logic [6:0] code;
   logic [15:0] edit_value;
   logic [15:0] store [0:DEPTH-1];

   wire is_param = (group != grp_monitor);
   wire [6:0] code_limit = is_param ? 7'(CODES - 1) : MONITOR_CODES;
   wire [6:0] cur_idx = param_index(group, code);
   wire [15:0] cur_store = is_param ? store[cur_idx] : 16'h0000;
   wire showing_setting = (view == view_value) && is_param;
   wire invalid = showing_setting && (edit_value > VALUE_MAX);
   wire [6:0] freq_idx = param_index(grp_basic, FREQUENCY_SETTING_PARAM);
   wire [6:0] dir_idx = param_index(grp_basic, PANEL_ROTATION_DIRECTION_PARAM);
   wire panel_run = key_press[KEY_RUN] && run_source_panel;
   wire [15:0] mon_value =
      (code == OUTPUT_FREQUENCY_MONITOR_CODE) ? mon_out_freq :
      (code == OUTPUT_CURRENT_MONITOR_CODE) ? mon_out_current :
      (code == FREQ_REFERENCE_MONITOR_CODE) ? mon_freq_ref :
      (code == OUTPUT_VOLTAGE_MONITOR_CODE) ? mon_out_voltage :
      (code == OUTPUT_POWER_MONITOR_CODE) ? mon_out_power : mon_load_ratio;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         group <= grp_monitor;
         code <= OUTPUT_FREQUENCY_MONITOR_CODE;
         view <= view_value;
         edit_value <= 16'h0000;
         param_commit <= 1'b0;
         for (int i = 0; i < DEPTH; i++) begin
            store[i] <= PARAM_RESET;
         end
         store[param_index(grp_basic, FREQUENCY_SETTING_PARAM)] <= FREQ_SETTING_RESET;
      end else begin
         param_commit <= 1'b0;
         if (long_fire) begin
            group <= grp_monitor;
            code <= OUTPUT_FREQUENCY_MONITOR_CODE;
            view <= view_value;
         end else if (panel_run) begin
            group <= grp_monitor;
            code <= FREQ_REFERENCE_MONITOR_CODE;
            view <= view_value;
         end else begin
            case (view)
               view_code: begin
                  if (key_press[KEY_MODE]) begin
                     if (code == GROUP_HEADER_CODE) begin
                        group <= next_group(group);
                     end else begin
                        view <= view_value;
                        edit_value <= cur_store;
                     end
                  end else if (key_press[KEY_UP]) begin
                     code <= (code >= code_limit) ? GROUP_HEADER_CODE : code + 7'h01;
                  end else if (key_press[KEY_DOWN]) begin
                     code <= (code == GROUP_HEADER_CODE) ? code_limit : code - 7'h01;
                  end
               end
               view_value: begin
                  if (key_press[KEY_MODE]) begin
                     view <= view_code;
                  end else if (is_param) begin
                     if (key_press[KEY_ENTER] && !invalid) begin
                        store[cur_idx] <= edit_value;
                        param_commit <= 1'b1;
                        view <= view_code;
                     end else if (key_press[KEY_UP] && edit_value != 16'hFFFF) begin
                        edit_value <= edit_value + 16'h0001;
                     end else if (key_press[KEY_DOWN] && edit_value != 16'h0000) begin
                        edit_value <= edit_value - 16'h0001;
                     end
                  end
               end
               default: view <= view_code;
            endcase
         end
      end
   end

   assign frequency_setting = store[freq_idx];

   // ----------------------------------------
   // drive core requests
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         run_req <= 1'b0;
         run_reverse <= 1'b0;
         stop_req <= 1'b0;
         error_reset_req <= 1'b0;
      end else begin
         run_req <= panel_run;
         if (panel_run) begin
            run_reverse <= store[dir_idx][0];
         end
         stop_req <= key_press[KEY_STOP] && !drive_error;
         error_reset_req <= key_press[KEY_STOP] && drive_error;
      end
   end

   // ----------------------------------------
   // lamps and display
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         power_lamp <= 1'b0;
         alarm_lamp <= 1'b0;
         running_lamp <= 1'b0;
         programming_indicator <= 1'b0;
         run_source_lamp <= 1'b0;
         unit_lamp <= 5'h01;
         display_group <= 3'h0;
         display_code <= 7'h00;
         display_is_value <= 1'b0;
         display_value <= 16'h0000;
      end else begin
         power_lamp <= 1'b1;
         alarm_lamp <= drive_error;
         running_lamp <= drive_running;
         programming_indicator <= showing_setting && (!invalid || blink_phase);
         run_source_lamp <= run_source_panel;
         unit_lamp <= unit_of(group, code);
         display_group <= group;
         display_code <= code;
         display_is_value <= (view == view_value);
         if (view == view_value) begin
            display_value <= is_param ? edit_value : mon_value;
         end else begin
            display_value <= 16'h0000;
         end
      end
   end

endmodule : drive_operator_panel_logic

/* File: panel_pkg.sv */
// Purpose: constants and types of the drive operator panel
// Assumes: 25 MHz core clock
// Notes: times are kept in ms, cycle counts derive from them
package panel_pkg;
   localparam int CLK_HZ = 25_000_000;
   localparam int LONG_PRESS_MS = 3000;
   localparam int LONG_PRESS_CYCLES = (CLK_HZ / 1000) * LONG_PRESS_MS;
   localparam int DEBOUNCE_MS = 1;
   localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;
   localparam int BLINK_MS = 250;
   localparam int BLINK_CYCLES = (CLK_HZ / 1000) * BLINK_MS;
   localparam int VALUE_W = 16;
   localparam int CODE_W = 7;
   localparam logic [15:0] FREQ_SETTING_RESET = 16'h0006;
   localparam logic [15:0] PARAM_RESET = 16'h0000;
   localparam logic [6:0] GROUP_HEADER_CODE = 7'h00;
   localparam logic [6:0] OUTPUT_FREQUENCY_MONITOR_CODE = 7'h01;
   localparam logic [6:0] OUTPUT_CURRENT_MONITOR_CODE = 7'h02;
   localparam logic [6:0] FREQ_REFERENCE_MONITOR_CODE = 7'h03;
   localparam logic [6:0] OUTPUT_VOLTAGE_MONITOR_CODE = 7'h04;
   localparam logic [6:0] OUTPUT_POWER_MONITOR_CODE = 7'h05;
   localparam logic [6:0] FREQUENCY_SETTING_PARAM = 7'h01;
   localparam logic [6:0] PANEL_ROTATION_DIRECTION_PARAM = 7'h04;
   localparam int UNIT_HZ = 0;
   localparam int UNIT_V = 1;
   localparam int UNIT_A = 2;
   localparam int UNIT_KW = 3;
   localparam int UNIT_PCT = 4;
   localparam int KEY_RUN = 0;
   localparam int KEY_STOP = 1;
   localparam int KEY_MODE = 2;
   localparam int KEY_ENTER = 3;
   localparam int KEY_UP = 4;
   localparam int KEY_DOWN = 5;
   localparam int NUM_KEYS = 6;
   typedef enum logic [2:0] {
      grp_monitor, grp_basic, grp_ext_a, grp_ext_b, grp_ext_c, grp_ext_h
   } group_t;
   typedef enum logic {view_code, view_value} view_t;
endpackage : panel_pkg

/* File: drive_operator_panel_logic_sva.sv */
// Purpose: port-level checks of the operator panel
// Assumes: one clock domain, reset_n active low
// Notes: lamps follow their inputs one cycle late
`timescale 1ns/1ps
module drive_operator_panel_logic_sva
   import panel_pkg::*;
#(
   parameter logic [15:0] VALUE_MAX = 16'h0FFF
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // core status
   input wire logic drive_error,
   input wire logic drive_running,
   input wire logic run_source_panel,
   // requests
   input wire logic run_req,
   input wire logic stop_req,
   input wire logic error_reset_req,
   // lamps
   input wire logic power_lamp,
   input wire logic alarm_lamp,
   input wire logic running_lamp,
   input wire logic programming_indicator,
   input wire logic run_source_lamp,
   input wire logic [4:0] unit_lamp,
   // display
   input wire logic [2:0] display_group,
   input wire logic [6:0] display_code,
   input wire logic display_is_value,
   input wire logic [15:0] display_value
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   sequence s_freq_ref_view;
      display_group == 3'h0 && display_code == FREQ_REFERENCE_MONITOR_CODE && display_is_value;
   endsequence
   sequence s_setting_ok;
      display_is_value && display_group != 3'h0 && display_value <= VALUE_MAX;
   endsequence
   property p_power; $past(reset_n) |-> power_lamp; endproperty
   property p_alarm; $past(reset_n) |-> alarm_lamp == $past(drive_error); endproperty
   property p_running; $past(reset_n) |-> running_lamp == $past(drive_running); endproperty
   property p_source; $past(reset_n) |-> run_source_lamp == $past(run_source_panel); endproperty
   property p_unit; $onehot(unit_lamp); endproperty
   property p_run_gate; run_req |-> $past(run_source_panel) ##1 !run_req; endproperty
   property p_run_view; run_req |-> ##[0:1] s_freq_ref_view; endproperty
   property p_stop; stop_req |-> !$past(drive_error) ##1 !stop_req; endproperty
   property p_err_reset; error_reset_req |-> $past(drive_error) && !stop_req; endproperty
   property p_prog; s_setting_ok [*2] |-> programming_indicator; endproperty
   a_power: assert property (p_power) else $error("power lamp off");
   a_alarm: assert property (p_alarm) else $error("alarm lamp wrong");
   a_running: assert property (p_running) else $error("running lamp wrong");
   a_source: assert property (p_source) else $error("run source lamp wrong");
   a_unit: assert property (p_unit) else $error("unit lamps not one-hot");
   a_run_gate: assert property (p_run_gate) else $error("run request not allowed");
   a_run_view: assert property (p_run_view) else $error("run view wrong");
   a_stop: assert property (p_stop) else $error("stop request wrong");
   a_err_reset: assert property (p_err_reset) else $error("error reset wrong");
   a_prog: assert property (p_prog) else $error("programming lamp off");
endmodule : drive_operator_panel_logic_sva

bind drive_operator_panel_logic drive_operator_panel_logic_sva #(.VALUE_MAX(VALUE_MAX)) i_sva (.*);

/* File: drive_core_model.sv */
// Purpose: behavioural drive core facing the panel
// Assumes: requests are one-cycle pulses
// Notes: fault is a bench command that raises the error flag
`timescale 1ns/1ps
module drive_core_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // panel requests, setting and bench fault command
   input wire logic run_req,
   input wire logic stop_req,
   input wire logic error_reset_req,
   input wire logic fault,
   input wire logic [15:0] frequency_setting,
   // status and monitors
   output logic drive_error,
   output logic drive_running,
   output logic [15:0] mon_out_freq,
   output logic [15:0] mon_out_current,
   output logic [15:0] mon_freq_ref,
   output logic [15:0] mon_out_voltage,
   output logic [15:0] mon_out_power,
   output logic [15:0] mon_load_ratio
);
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         drive_error <= 1'b0;
         drive_running <= 1'b0;
      end else begin
         drive_error <= fault | (drive_error & ~error_reset_req);
         drive_running <= ~fault & (run_req | (drive_running & ~stop_req));
      end
   end
   assign mon_freq_ref = frequency_setting;
   assign mon_out_freq = drive_running ? frequency_setting : 16'h0000;
   assign mon_out_current = 16'h0123;
   assign mon_out_voltage = 16'h0190;
   assign mon_out_power = 16'h0022;
   assign mon_load_ratio = 16'h0050;
endmodule : drive_core_model

/* File: tb_drive_operator_panel_logic.sv */
// Purpose: self-checking bench of the operator panel
// Assumes: short debounce, blink and long-press counts
// Notes: request pulses are counted, then compared after each loop run and stop press, the error reset and two enter presses
`timescale 1ns/1ps
module tb_drive_operator_panel_logic;
   import panel_pkg::*;
   logic core_clk = 0, reset_n = 0, fault = 0, run_source_panel = 1;
   logic [5:0] keys = '0;
   logic key_run, key_stop_reset, key_mode, key_enter, key_up, key_down;
   logic drive_error, drive_running, run_req, run_reverse, stop_req, error_reset_req;
   logic param_commit, power_lamp, alarm_lamp, running_lamp, programming_indicator;
   logic run_source_lamp, display_is_value;
   logic [15:0] mon_out_freq, mon_out_current, mon_freq_ref, mon_out_voltage;
   logic [15:0] mon_out_power, mon_load_ratio, frequency_setting, display_value;
   logic [4:0] unit_lamp;
   logic [2:0] display_group;
   logic [6:0] display_code;
   int fail_count = 0, n_compared = 0, n_run = 0, n_stop = 0, n_err = 0, n_commit = 0;
   int s, ex, tg;
   assign {key_down, key_up, key_enter, key_mode, key_stop_reset, key_run} = keys;
   always #20 core_clk = ~core_clk;
   drive_operator_panel_logic #(.LONG_PRESS_CYCLES_P(200), .DEBOUNCE_CYCLES_P(4),
      .BLINK_CYCLES_P(8), .VALUE_MAX(16'h0008)) i_drive_operator_panel_logic (.*);
   drive_core_model i_drive_core_model (.*);
   always @(posedge core_clk) begin
      n_run <= n_run + run_req;
      n_stop <= n_stop + stop_req;
      n_err <= n_err + error_reset_req;
      n_commit <= n_commit + param_commit;
   end
   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   function automatic logic [4:0] unit_of(int c);
      case (c)
         2: return 5'h04;
         4: return 5'h02;
         5: return 5'h08;
         6: return 5'h10;
         default: return 5'h01;
      endcase
   endfunction : unit_of
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic hold(int k, int n, int times = 1);
      repeat (times) begin
         @(posedge core_clk) keys[k] <= 1'b1;
         repeat (n) @(posedge core_clk);
         keys[k] <= 1'b0;
         repeat (20) @(posedge core_clk);
         #1;
      end
   endtask : hold
   task automatic toggles();
      logic prev;
      tg = 0;
      prev = programming_indicator;
      repeat (24) begin
         @(posedge core_clk) #1;
         if (programming_indicator !== prev) tg++;
         prev = programming_indicator;
      end
   endtask : toggles
   task report_and_stop();
      if (fail_count == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      report_and_stop();
   end
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      void'($urandom(26));
      repeat (6) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      chk(power_lamp, 1);
      chk(display_code, 1);
      chk(frequency_setting, 16'h0006);
      for (int i = 0; i < 6; i++) begin
         s = (i < 2) ? i : $urandom % 2;
         @(posedge core_clk) run_source_panel <= s[0];
         ex = n_run + s;
         hold(KEY_RUN, 20);
         chk(n_run, ex);
         chk(run_source_lamp, s);
         chk(running_lamp, s);
         if (s) chk(display_code, FREQ_REFERENCE_MONITOR_CODE);
         if (s) chk(display_value, 16'h0006);
         chk(run_reverse, 0);
         ex = n_stop + 1;
         hold(KEY_STOP, 20);
         chk(n_stop, ex);
         chk(running_lamp, 0);
      end
      @(posedge core_clk) fault <= 1'b1;
      @(posedge core_clk) fault <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      chk(alarm_lamp, 1);
      ex = n_stop;
      hold(KEY_STOP, 20);
      chk(n_err, 1);
      chk(n_stop, ex);
      chk(alarm_lamp, 0);
      hold(KEY_MODE, 230);
      chk({display_group, display_code, display_is_value}, 11'h003);
      hold(KEY_MODE, 20);
      for (int c = 1; c <= 6; c++) begin
         chk(display_code, c);
         chk(unit_lamp, unit_of(c));
         hold(KEY_UP, 20);
      end
      chk(display_code, 0);
      hold(KEY_DOWN, 20);
      chk(display_code, 6);
      hold(KEY_DOWN, 20, 4);
      hold(KEY_MODE, 20);
      chk(display_value, mon_out_current);
      hold(KEY_MODE, 20);
      hold(KEY_DOWN, 20, 2);
      hold(KEY_MODE, 20);
      chk(display_group, 1);
      hold(KEY_UP, 20);
      hold(KEY_MODE, 20);
      chk(display_value, 16'h0006);
      hold(KEY_UP, 20, 3);
      chk(display_value, 16'h0009);
      toggles();
      chk(tg > 1, 1);
      hold(KEY_ENTER, 20);
      chk({n_commit[0], display_is_value}, 2'h1);
      hold(KEY_MODE, 20, 2);
      chk(display_value, 16'h0006);
      toggles();
      chk({tg == 0, programming_indicator}, 2'h3);
      hold(KEY_UP, 20, 3);
      hold(KEY_DOWN, 20);
      chk(display_value, 16'h0008);
      hold(KEY_ENTER, 20);
      chk(n_commit, 1);
      chk(frequency_setting, 16'h0008);
      hold(KEY_UP, 20, 3);
      hold(KEY_MODE, 20);
      hold(KEY_UP, 20);
      hold(KEY_ENTER, 20);
      hold(KEY_MODE, 230);
      @(posedge core_clk) run_source_panel <= 1'b1;
      hold(KEY_RUN, 20);
      chk(run_reverse, 1);
      chk(display_value, 16'h0008);
      report_and_stop();
   end
endmodule : tb_drive_operator_panel_logic
